// [hw/edp_ctrl.sv]
// Contract
// - Row address captured at row strobe fall: 11 bits (2K) or 12 (4K).
// - Column address captured by column strobe: 11 bits (2K) or 10 (4K).
// - Write strobe high selects read, low selects write.
// - Controller raises output gate before driving write data on late writes.
// - Page opens on row strobe fall, columns follow, row strobe rise closes.
// - Controller covers every row address within the refresh_window.
// - Self refresh starts from column-first refresh with long row strobe low.
// - Extended period allows one row every 31.25 us (4K) or 62.5 us (2K).
// - Self refresh ends after row strobe is held high for exit time.
// - Distributed refresh needs no burst after self refresh exit.
// - After power-up wait the pause, then eight refresh cycles before access.
// - Self refresh entry holds row strobe low at least 100 us.
// - Self refresh exit precharge lasts at least 90 or 105 ns.
`default_nettype none
module edp_ctrl
    import edp_pkg::*;
#(
    parameter int ROW_W = 12,
    parameter int COL_W = 10,
    parameter int INIT_CYC = INIT_CYC_DOC,
    parameter int SRE_CYC = SRE_CYC_DOC,
    parameter int REFI_CYC = REFI_CYC_DOC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic [ROW_W+COL_W-1:0] req_addr_i,
    input wire logic [DQ_W-1:0] req_wdata_i,
    output logic rd_valid_o,
    output logic [DQ_W-1:0] rd_data_o,
    input wire logic rd_ready_i,
    input wire logic self_refresh_req_i,
    output logic self_refresh_active_o,
    output logic init_done_o,
    output logic row_strobe_n_o,
    output logic column_strobe_n_o,
    output logic write_strobe_n_o,
    output logic output_gate_n_o,
    output logic [ADDR_PINS-1:0] addr_o,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_o
);
    // ==========================================================
    // State machine codes
    typedef enum logic [3:0] {
        ST_INIT = 4'h0,
        ST_IDLE = 4'h1,
        ST_ROW = 4'h2,
        ST_COL = 4'h3,
        ST_PRE = 4'h4,
        ST_REF_COL = 4'h5,
        ST_REF_ROW = 4'h6,
        ST_SELF = 4'h7,
        ST_SR_X = 4'h8
    } edp_state_type;

    edp_state_type state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] ref_cnt_q;
    logic [3:0] ref_left_q;
    logic ref_pend_q;
    logic sr_go_q;
    logic rd_q;
    logic [ROW_W-1:0] row_q;
    logic [COL_W-1:0] col_q;
    logic [DQ_W-1:0] dq_s1_q;
    logic [DQ_W-1:0] dq_s2_q;
    logic [DQ_W-1:0] sk_q;
    logic sk_v_q;

    // ==========================================================
    // Decodes
    wire logic done = (cnt_q == '0);
    wire logic accept = (state_q == ST_IDLE) && req_ready_o && req_valid_i;
    wire logic push = (state_q == ST_COL) && done && rd_q;
    wire logic pop = rd_valid_o && rd_ready_i;
    wire logic ref_tick = (ref_cnt_q == CNT_W'(REFI_CYC - 1));
    wire logic ref_clr = (state_q == ST_IDLE) && !accept && ref_pend_q;
    wire logic ref_need = ref_pend_q || (ref_left_q != '0);
    wire logic [ADDR_PINS-1:0] row_pins = ADDR_PINS'(row_q);
    wire logic [ADDR_PINS-1:0] col_pins = ADDR_PINS'(col_q); // Upper pins driven low

    // Data pins pass two flops before anything reads them
    always_ff @(posedge clk_sys_i) begin
        dq_s1_q <= dq_i;
        dq_s2_q <= dq_s1_q;
    end

    // ==========================================================
    // Refresh interval timer; a new tick beats a clear in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || ref_tick) begin
            ref_cnt_q <= '0;
        end else begin
            ref_cnt_q <= ref_cnt_q + 1'b1;
        end
        if (!rst_n_i) begin
            ref_pend_q <= 1'b0;
        end else begin
            ref_pend_q <= ref_tick || (state_q == ST_SR_X && done) || (ref_pend_q && !ref_clr);
        end
    end

    // ==========================================================
    // Two-entry read buffer: output stage plus skid, so a stalled reader loses nothing
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= '0;
            sk_v_q <= 1'b0;
            sk_q <= '0;
        end else if (!rd_valid_o || pop) begin
            rd_valid_o <= sk_v_q || push;
            rd_data_o <= sk_v_q ? sk_q : dq_s2_q;
            sk_v_q <= sk_v_q && push;
            sk_q <= dq_s2_q;
        end else if (push) begin
            sk_v_q <= 1'b1;
            sk_q <= dq_s2_q;
        end
    end

    // ==========================================================
    // Main sequencer; one access per page keeps the row pulse short and bounded
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= ST_INIT;
            cnt_q <= CNT_W'(INIT_CYC - 1);
            ref_left_q <= '0;
            sr_go_q <= 1'b0;
            rd_q <= 1'b0;
            row_q <= '0;
            col_q <= '0;
            req_ready_o <= 1'b0;
            init_done_o <= 1'b0;
            self_refresh_active_o <= 1'b0;
            row_strobe_n_o <= 1'b1;
            column_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            output_gate_n_o <= 1'b1;
            addr_o <= '0;
            dq_o <= '0;
            dq_oe_o <= 1'b0;
        end else begin
            req_ready_o <= 1'b0;
            if (!done) begin
                cnt_q <= cnt_q - 1'b1;
            end
            unique case (state_q)
                ST_INIT: if (done) begin
                    ref_left_q <= 4'(INIT_REFRESHES);
                    state_q <= ST_IDLE;
                end
                ST_IDLE: if (accept) begin
                    {row_q, col_q} <= req_addr_i;
                    rd_q <= !req_write_i;
                    addr_o <= ADDR_PINS'(req_addr_i[ROW_W+COL_W-1:COL_W]);
                    row_strobe_n_o <= 1'b0;
                    write_strobe_n_o <= !req_write_i; // Early write: low before column fall
                    dq_o <= req_wdata_i;
                    dq_oe_o <= req_write_i; // Gate already high while driving
                    cnt_q <= CNT_W'(RCD_CYC - 1);
                    state_q <= ST_ROW;
                end else if (ref_need || (self_refresh_req_i && init_done_o)) begin
                    sr_go_q <= !ref_need;
                    column_strobe_n_o <= 1'b0; // Column first, write strobe high
                    cnt_q <= CNT_W'(CSR_CYC - 1);
                    state_q <= ST_REF_COL;
                end else begin
                    req_ready_o <= init_done_o && !sk_v_q && !self_refresh_req_i;
                end
                ST_ROW: if (done) begin
                    addr_o <= col_pins;
                    column_strobe_n_o <= 1'b0;
                    output_gate_n_o <= !rd_q;
                    cnt_q <= rd_q ? CNT_W'(COL_RD_CYC - 1) : CNT_W'(COL_WR_CYC - 1);
                    state_q <= ST_COL;
                end
                ST_COL: if (done) begin
                    row_strobe_n_o <= 1'b1; // Both strobes high: standby
                    column_strobe_n_o <= 1'b1; // Column never held low past the page
                    write_strobe_n_o <= 1'b1;
                    output_gate_n_o <= 1'b1;
                    dq_oe_o <= 1'b0;
                    cnt_q <= CNT_W'(RP_CYC - 1);
                    state_q <= ST_PRE;
                end
                ST_PRE: if (done) begin
                    state_q <= ST_IDLE;
                end
                ST_REF_COL: if (done) begin
                    row_strobe_n_o <= 1'b0;
                    cnt_q <= CNT_W'(RAS_CYC - 1);
                    state_q <= ST_REF_ROW;
                end
                ST_REF_ROW: if (done) begin
                    if (sr_go_q && self_refresh_req_i) begin
                        self_refresh_active_o <= 1'b1;
                        cnt_q <= CNT_W'(SRE_CYC - 1);
                        state_q <= ST_SELF;
                    end else begin
                        if (ref_left_q != '0) begin
                            ref_left_q <= ref_left_q - 1'b1;
                            init_done_o <= (ref_left_q == 4'h1);
                        end
                        row_strobe_n_o <= 1'b1;
                        column_strobe_n_o <= 1'b1;
                        cnt_q <= CNT_W'(RP_CYC - 1);
                        state_q <= ST_PRE;
                    end
                end
                ST_SELF: if (done && !self_refresh_req_i) begin
                    self_refresh_active_o <= 1'b0;
                    row_strobe_n_o <= 1'b1;
                    column_strobe_n_o <= 1'b1;
                    cnt_q <= CNT_W'(SR_EXIT_CYC - 1);
                    state_q <= ST_SR_X;
                end
                ST_SR_X: if (done) begin
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Checks on the pins the controller drives, on init_done_o and on refresh service
    logic [CNT_W-1:0] ras_lo_q;
    logic [CNT_W-1:0] ras_hi_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ras_lo_q <= '0;
            ras_hi_q <= '0;
        end else begin
            ras_lo_q <= row_strobe_n_o ? '0 : ras_lo_q + CNT_W'(ras_lo_q != '1);
            ras_hi_q <= !row_strobe_n_o ? '0 : ras_hi_q + CNT_W'(ras_hi_q != '1);
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence access_col_s;
        $fell(column_strobe_n_o) && !row_strobe_n_o;
    endsequence

    cbr_we_high_a: assert property ($fell(column_strobe_n_o) && row_strobe_n_o |-> write_strobe_n_o)
        else $error("column-first refresh with write strobe low");
    gate_on_write_a: assert property (dq_oe_o |-> output_gate_n_o)
        else $error("write data driven while output gate low");
    early_write_a: assert property (access_col_s and !write_strobe_n_o |-> $past(!write_strobe_n_o))
        else $error("write strobe did not fall before column strobe");
    row_addr_a: assert property ($fell(row_strobe_n_o) && column_strobe_n_o |-> addr_o == row_pins)
        else $error("row address not on pins at row strobe fall");
    col_addr_a: assert property (access_col_s |-> addr_o == col_pins)
        else $error("column address not on pins at column strobe fall");
    init_first_a: assert property (access_col_s |-> init_done_o)
        else $error("access before wake-up refreshes");
    sr_entry_a: assert property ($rose(row_strobe_n_o) && $past(self_refresh_active_o)
        |-> $past(ras_lo_q) >= CNT_W'(SRE_CYC))
        else $error("self refresh row strobe low too short");
    sr_exit_a: assert property ($fell(self_refresh_active_o) |-> row_strobe_n_o [*8])
        else $error("row strobe not held high on self refresh exit");
    precharge_a: assert property ($fell(row_strobe_n_o) |-> $past(ras_hi_q) >= CNT_W'(RP_CYC))
        else $error("row precharge too short");
    refresh_served_a: assert property ($rose(ref_pend_q) && init_done_o && !self_refresh_req_i
        && !self_refresh_active_o |-> ##[1:64] !ref_pend_q)
        else $error("pending refresh not served");
endmodule : edp_ctrl
`default_nettype wire

// [hw/edp_pkg.sv]
`default_nettype none
// ==========================================================
// Shared constants for the page-mode DRAM host controller
package edp_pkg;
    // System clock period in picoseconds (250 MHz)
    localparam int CLK_PS = 4000;
    // Pin and word widths
    localparam int ADDR_PINS = 12;
    localparam int DQ_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 16;
    // Wake-up refresh count after the initial pause
    localparam int INIT_REFRESHES = 8;
    // Device timings, each in its natural unit
    localparam int T_RCD_NS = 14;
    localparam int T_RAS_NS = 60;
    localparam int T_RP_NS = 40;
    localparam int T_CSR_NS = 5;
    localparam int T_SR_EXIT_NS = 105;
    localparam int T_INIT_US = 100;
    localparam int T_SRE_US = 100;
    // Distributed refresh spacing: 31.25 us (4K) and 62.5 us (2K), kept in ns
    localparam int T_REFI_4K_NS = 31250;
    localparam int T_REFI_2K_NS = 62500;
    // Least times round up, longest times round down
    localparam int RCD_CYC = (T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RAS_CYC = (T_RAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RP_CYC = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CSR_CYC = (T_CSR_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SR_EXIT_CYC = (T_SR_EXIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int INIT_CYC_DOC = (T_INIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int SRE_CYC_DOC = (T_SRE_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int REFI_CYC_DOC = (T_REFI_4K_NS * 1000) / CLK_PS;
    // Column phase lengths: writes fill out the row pulse, reads add sync latency
    localparam int COL_WR_CYC = RAS_CYC - RCD_CYC;
    localparam int COL_RD_CYC = RAS_CYC - RCD_CYC + SYNC_STAGES;
endpackage : edp_pkg
`default_nettype wire

// [verification/edp_dram_model.sv]
`default_nettype none
// ==========================================================
// Behavioural x4 page-mode DRAM seen from its pins
module edp_dram_model #(
    parameter int ACC_NS = 10,
    parameter int SRE_NS = 120
) (
    input wire logic row_strobe_n_i,
    input wire logic column_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic output_gate_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [3:0] dq_i,
    output logic [3:0] dq_o,
    output logic dq_oe_o,
    output var int refresh_cnt_o,
    output var int self_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] mem_q [int];
    logic [11:0] row_q = 12'h000;
    logic [11:0] rcnt_q = 12'h000;
    logic [3:0] out_q = 4'h0;
    logic cf_ref_q = 1'b0;
    logic rd_q = 1'b0;
    logic [21:0] key;
    realtime low_t;
    assign key = {row_q, addr_i[9:0]};
    initial begin
        refresh_cnt_o = 0;
        self_cnt_o = 0;
    end
    // Row fall opens a page, or starts a counter-addressed refresh
    always @(negedge row_strobe_n_i) begin
        low_t = $realtime;
        // Pins change in the same step as the strobe; look once they have settled
        #1;
        cf_ref_q = ~column_strobe_n_i;
        row_q = cf_ref_q ? rcnt_q : addr_i;
        if (cf_ref_q) begin
            rcnt_q = rcnt_q + 12'h001;
            refresh_cnt_o++;
        end
    end
    // Column fall in an open page: early write stores, read fetches
    always @(negedge column_strobe_n_i) begin
        // Address and data change with the strobe; sample after they settle
        #1;
        if (!row_strobe_n_i && !cf_ref_q && !write_strobe_n_i) begin
            mem_q[key] = dq_i;
        end else if (!row_strobe_n_i && !cf_ref_q) begin
            out_q = mem_q.exists(key) ? mem_q[key] : 4'h0;
            rd_q = 1'b1;
        end
    end
    // A long refresh low is self refresh; the later strobe rise ends output
    always @(posedge row_strobe_n_i) begin
        if (cf_ref_q && ($realtime - low_t) >= SRE_NS) self_cnt_o++;
        if (column_strobe_n_i) rd_q = 1'b0;
    end
    always @(posedge column_strobe_n_i) begin
        if (row_strobe_n_i) rd_q = 1'b0;
    end
    // Gate or write activity with the column high leaves the pins open
    always @(posedge output_gate_n_i or negedge write_strobe_n_i) begin
        if (column_strobe_n_i) rd_q = 1'b0;
    end
    // Late write stores only with the gate high; with it low the read word stays out
    always @(negedge write_strobe_n_i) begin
        #1;
        if (!row_strobe_n_i && !column_strobe_n_i && !cf_ref_q && output_gate_n_i) begin
            mem_q[key] = dq_i;
        end
    end
    // Slow access on purpose; released pins show the inverse of the last word
    assign #(ACC_NS) dq_oe_o = rd_q && !output_gate_n_i;
    assign dq_o = dq_oe_o ? out_q : ~out_q;
endmodule // edp_dram_model
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import edp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic vld = 1'b0;
    logic wr = 1'b0;
    logic [21:0] adr = 22'h000000;
    logic [3:0] wd = 4'h0;
    logic rrdy = 1'b1;
    logic sreq = 1'b0;
    logic rdy, rv, sact, idone, ras_n, cas_n, we_n, oe_n, c_oe, m_oe;
    logic [3:0] rd, c_dq, m_dq, bus;
    logic [11:0] pins;
    int refs, selfs, error_cnt = 0, checks = 0, n, r0;
    logic [3:0] shadow [int];
    logic [21:0] a_q [$];
    assign bus = c_oe ? c_dq : m_dq;
    edp_ctrl #(.INIT_CYC(40), .SRE_CYC(40), .REFI_CYC(200)) dut_u (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .req_valid_i(vld), .req_ready_o(rdy), .req_write_i(wr),
        .req_addr_i(adr), .req_wdata_i(wd), .rd_valid_o(rv), .rd_data_o(rd), .rd_ready_i(rrdy),
        .self_refresh_req_i(sreq), .self_refresh_active_o(sact), .init_done_o(idone),
        .row_strobe_n_o(ras_n), .column_strobe_n_o(cas_n), .write_strobe_n_o(we_n),
        .output_gate_n_o(oe_n), .addr_o(pins), .dq_i(bus), .dq_o(c_dq), .dq_oe_o(c_oe));
    edp_dram_model #(.ACC_NS(28), .SRE_NS(120)) dram_u (.row_strobe_n_i(ras_n),
        .column_strobe_n_i(cas_n), .write_strobe_n_i(we_n), .output_gate_n_i(oe_n),
        .addr_i(pins), .dq_i(bus), .dq_o(m_dq), .dq_oe_o(m_oe), .refresh_cnt_o(refs),
        .self_cnt_o(selfs));
    // ==========================================================
    // Clock, helpers and closing report
    initial forever #2 clk_sys_i = ~clk_sys_i;
    function automatic logic [3:0] exp_word(logic [21:0] a);
        return shadow[a];
    endfunction
    task automatic end_sim();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
        checks++;
        if (exp !== got) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask
    // Waits stay bounded; a bound that runs out ends the run
    task automatic give_up(logic ok);
        if (ok !== 1'b1) begin
            chk("wait", 4'h1, 4'h0);
            end_sim();
        end
    endtask
    task automatic issue(logic w, logic [21:0] a, logic [3:0] d);
        wr = w;
        adr = a;
        wd = d;
        vld = 1'b1;
        for (n = 0; n < 600 && rdy !== 1'b1; n++) tick();
        give_up(rdy);
        tick();
        vld = 1'b0;
        if (w) shadow[a] = d;
        // Let an edge pass so a following request never re-raises valid in the same step
        tick();
    endtask
    task automatic take(logic [21:0] a);
        for (n = 0; n < 60 && rv !== 1'b1; n++) tick();
        give_up(rv);
        chk("read_word", exp_word(a), rd);
        tick();
    endtask
    // Both ends never drive the shared data pins at once
    always @(negedge clk_sys_i) begin
        if (c_oe === 1'b1 && m_oe === 1'b1) chk("dq_drivers", 4'h1, 4'h2);
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(1556));
        repeat (3) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        for (n = 0; n < 1000 && idone !== 1'b1; n++) tick();
        give_up(idone);
        chk("wake_refreshes", 4'h8, 4'(refs));
        // Corner addresses, an overwrite, then random traffic read back later
        a_q = '{22'h000000, 22'h3FFFFF, 22'h3FF000, 22'h000FFF, 22'h000000};
        for (int i = 0; i < 24; i++) a_q.push_back(22'($urandom));
        foreach (a_q[i]) issue(1'b1, a_q[i], 4'($urandom));
        foreach (a_q[i]) begin
            issue(1'b0, a_q[i], 4'h0);
            take(a_q[i]);
        end
        // Stalled reader: two words buffer, a third request must wait
        rrdy = 1'b0;
        issue(1'b0, a_q[1], 4'h0);
        issue(1'b0, a_q[2], 4'h0);
        adr = a_q[3];
        wr = 1'b0;
        vld = 1'b1;
        r0 = 0;
        repeat (80) begin
            tick();
            if (rdy === 1'b1) r0++;
        end
        chk("ready_when_full", 4'h0, 4'(r0));
        rrdy = 1'b1;
        take(a_q[1]);
        take(a_q[2]);
        for (n = 0; n < 100 && rdy !== 1'b1; n++) tick();
        give_up(rdy);
        tick();
        vld = 1'b0;
        take(a_q[3]);
        // Self refresh: entered from a column-first cycle, left after precharge
        sreq = 1'b1;
        for (n = 0; n < 400 && sact !== 1'b1; n++) tick();
        give_up(sact);
        repeat (60) tick();
        chk("row_held_low", 4'h0, {3'h0, ras_n});
        chk("ready_in_self", 4'h0, {3'h0, rdy});
        sreq = 1'b0;
        for (n = 0; n < 200 && sact !== 1'b0; n++) tick();
        give_up(~sact);
        issue(1'b0, a_q[5], 4'h0);
        take(a_q[5]);
        chk("self_entries", 4'h1, 4'(selfs));
        // Idle spell: periodic refresh keeps coming
        r0 = refs;
        repeat (450) tick();
        chk("idle_refreshes", 4'h1, {3'h0, (refs - r0) inside {2, 3}});
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
